// >>> design/otpp_prog_ctrl.sv
// What this block does
// - Each byte is written by one low chip-select pulse with program supply up.
// - Every program pulse lasts between 95 and 105 microseconds.
// - Programming starts with the address at the lowest location.
// - Both supplies go to programming level before any pulse.
// - First pass gives each address one pulse, with no reads in between.
// - Second pass verifies each byte; mismatch gets single pulses, at most ten.
// - A byte still wrong after ten pulses stops the run as failed.
// - A verified byte advances the address until all are checked.
// - After the last byte passes, both supplies return to read level.
// - At read level every byte is read back; any mismatch fails the part.
// - Identification mode is entered by raising the id voltage line.
module otpp_prog_ctrl #(
  parameter int PULSE_CYC = otpp_pkg::PULSE_CYC,
  parameter logic [otpp_pkg::ADDR_W-1:0] LAST_A = otpp_pkg::LAST_ADDR
) (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  // Job control
  input  wire logic                          prog_start,
  input  wire logic                          id_start,
  output logic                               busy,
  output logic                               done,
  output logic                               pass,
  output logic                               fail,
  output logic [otpp_pkg::ADDR_W-1:0]        fail_addr,
  output logic [otpp_pkg::DATA_W-1:0]        mfr_code,
  output logic [otpp_pkg::DATA_W-1:0]        dev_code,
  // Source image
  output logic [otpp_pkg::ADDR_W-1:0]        src_addr,
  input  wire logic [otpp_pkg::DATA_W-1:0]   src_data,
  // Device pins
  output logic [otpp_pkg::ADDR_W-1:0]        mem_addr,
  output logic                               ce_n,
  output logic                               oe_n,
  input  wire logic [otpp_pkg::DATA_W-1:0]   data_out_lines_in,
  output logic [otpp_pkg::DATA_W-1:0]        data_out_lines_out,
  output logic                               data_out_lines_oe_n,
  // Supply switches
  output logic                               vcc_prog_en,
  output logic                               vpp_prog_en,
  output logic                               id_voltage_line_en
);
  import otpp_pkg::*;

  localparam logic [TMR_W-1:0] PULSE_LD = PULSE_CYC[TMR_W-1:0];
  localparam int               PULSE_CHK = PULSE_CYC;

  // ****************************************
  // State
  // ****************************************
  otpp_state_t       state_r, state_nxt;
  otpp_phase_t       phase_r, phase_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic              ce_n_r, ce_n_nxt;
  logic              oe_n_r, oe_n_nxt;
  logic              doe_n_r, doe_n_nxt;
  logic              vcc_r, vcc_nxt;
  logic              vpp_r, vpp_nxt;
  logic              hv_r, hv_nxt;
  logic              match_r, match_nxt;
  logic              pass_r, pass_nxt;
  logic              fail_r, fail_nxt;
  logic              done_r, done_nxt;
  logic [ADDR_W-1:0] fail_addr_r, fail_addr_nxt;
  logic [DATA_W-1:0] mfr_r, mfr_nxt;
  logic [DATA_W-1:0] dev_r, dev_nxt;
  logic              try_clr, try_inc, try_lim;
  logic [3:0]        try_cnt;
  logic              last;

  otpp_tmr_if tmr_if ();

  otpp_delay u_delay (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tmr     (tmr_if.tmr)
  );

  otpp_retry u_retry (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clr     (try_clr),
    .inc     (try_inc),
    .count   (try_cnt),
    .limit   (try_lim)
  );

  // Dwell of each timed state; the data setup gets one extra cycle because
  // the byte is taken from the source image during the first cycle.
  function automatic logic [TMR_W-1:0] dwell(input otpp_state_t s);
    case (s)
      ST_VCCUP, ST_VPPUP, ST_PHOLD,
      ST_RSET, ST_VPPDN, ST_VCCDN: dwell = SETUP_CYC[TMR_W-1:0];
      ST_PSET:                     dwell = SETUP_CYC[TMR_W-1:0] + 14'h0001;
      ST_PULSE:                    dwell = PULSE_LD;
      ST_ROE:                      dwell = DV_CYC[TMR_W-1:0];
      ST_FLOAT:                    dwell = FLOAT_CYC[TMR_W-1:0];
      default:                     dwell = '0;
    endcase
  endfunction

  assign last = (addr_r == LAST_A);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_nxt     = state_r;
    phase_nxt     = phase_r;
    addr_nxt      = addr_r;
    dout_nxt      = dout_r;
    vcc_nxt       = vcc_r;
    vpp_nxt       = vpp_r;
    hv_nxt        = hv_r;
    match_nxt     = match_r;
    pass_nxt      = pass_r;
    fail_nxt      = fail_r;
    fail_addr_nxt = fail_addr_r;
    mfr_nxt       = mfr_r;
    dev_nxt       = dev_r;
    done_nxt      = 1'b0;
    try_clr       = 1'b0;
    try_inc       = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (prog_start) begin
          phase_nxt = PH_FIRST;
          addr_nxt  = FIRST_ADDR;
          pass_nxt  = 1'b0;
          fail_nxt  = 1'b0;
          vcc_nxt   = 1'b1;
          state_nxt = ST_VCCUP;
        end else if (id_start) begin
          phase_nxt = PH_ID;
          addr_nxt  = FIRST_ADDR;
          hv_nxt    = 1'b1;
          state_nxt = ST_RSET;
        end
      end
      ST_VCCUP: begin
        if (tmr_if.done) begin
          vpp_nxt   = 1'b1;
          state_nxt = ST_VPPUP;
        end
      end
      ST_VPPUP: begin
        if (tmr_if.done) begin
          state_nxt = ST_PSET;
        end
      end
      ST_PSET: begin
        dout_nxt = src_data;
        if (tmr_if.done) begin
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (tmr_if.done) begin
          state_nxt = ST_PHOLD;
        end
      end
      ST_PHOLD: begin
        if (tmr_if.done) begin
          if (phase_r == PH_FIRST) begin
            if (last) begin
              phase_nxt = PH_VERIFY;
              addr_nxt  = FIRST_ADDR;
              try_clr   = 1'b1;
              state_nxt = ST_RSET;
            end else begin
              addr_nxt  = addr_r + 15'h0001;
              state_nxt = ST_PSET;
            end
          end else begin
            try_inc   = 1'b1;
            state_nxt = ST_RSET;
          end
        end
      end
      ST_RSET: begin
        if (tmr_if.done) begin
          state_nxt = ST_ROE;
        end
      end
      ST_ROE: begin
        if (tmr_if.done) begin
          match_nxt = (data_out_lines_in == src_data);
          if (phase_r == PH_ID) begin
            if (addr_r[0]) begin
              dev_nxt = data_out_lines_in;
            end else begin
              mfr_nxt = data_out_lines_in;
            end
          end
          state_nxt = ST_FLOAT;
        end
      end
      ST_FLOAT: begin
        if (tmr_if.done) begin
          case (phase_r)
            PH_VERIFY: begin
              if (match_r) begin
                try_clr = 1'b1;
                if (last) begin
                  vpp_nxt   = 1'b0;
                  state_nxt = ST_VPPDN;
                end else begin
                  addr_nxt  = addr_r + 15'h0001;
                  state_nxt = ST_RSET;
                end
              end else if (try_lim) begin
                fail_nxt      = 1'b1;
                fail_addr_nxt = addr_r;
                vpp_nxt       = 1'b0;
                state_nxt     = ST_VPPDN;
              end else begin
                state_nxt = ST_PSET;
              end
            end
            PH_FINAL: begin
              if (!match_r) begin
                fail_nxt      = 1'b1;
                fail_addr_nxt = addr_r;
                state_nxt     = ST_DONE;
              end else if (last) begin
                pass_nxt  = 1'b1;
                state_nxt = ST_DONE;
              end else begin
                addr_nxt  = addr_r + 15'h0001;
                state_nxt = ST_RSET;
              end
            end
            PH_ID: begin
              if (addr_r[0]) begin
                hv_nxt    = 1'b0;
                state_nxt = ST_DONE;
              end else begin
                addr_nxt  = addr_r + 15'h0001;
                state_nxt = ST_RSET;
              end
            end
            default: state_nxt = ST_DONE;
          endcase
        end
      end
      ST_VPPDN: begin
        if (tmr_if.done) begin
          vcc_nxt   = 1'b0;
          state_nxt = ST_VCCDN;
        end
      end
      ST_VCCDN: begin
        if (tmr_if.done) begin
          if (fail_r) begin
            state_nxt = ST_DONE;
          end else begin
            phase_nxt = PH_FINAL;
            addr_nxt  = FIRST_ADDR;
            state_nxt = ST_RSET;
          end
        end
      end
      ST_DONE: begin
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Pins follow the next state so they switch on the same edge as it.
    ce_n_nxt  = !(state_nxt inside {ST_PULSE, ST_RSET, ST_ROE});
    oe_n_nxt  = (state_nxt != ST_ROE);
    doe_n_nxt = !(state_nxt inside {ST_PSET, ST_PULSE, ST_PHOLD});
  end

  assign tmr_if.load  = (state_nxt != state_r) && (dwell(state_nxt) != '0);
  assign tmr_if.count = dwell(state_nxt);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      phase_r     <= PH_FIRST;
      addr_r      <= '0;
      dout_r      <= '0;
      ce_n_r      <= 1'b1;
      oe_n_r      <= 1'b1;
      doe_n_r     <= 1'b1;
      vcc_r       <= 1'b0;
      vpp_r       <= 1'b0;
      hv_r        <= 1'b0;
      match_r     <= 1'b0;
      pass_r      <= 1'b0;
      fail_r      <= 1'b0;
      done_r      <= 1'b0;
      fail_addr_r <= '0;
      mfr_r       <= '0;
      dev_r       <= '0;
    end else begin
      state_r     <= state_nxt;
      phase_r     <= phase_nxt;
      addr_r      <= addr_nxt;
      dout_r      <= dout_nxt;
      ce_n_r      <= ce_n_nxt;
      oe_n_r      <= oe_n_nxt;
      doe_n_r     <= doe_n_nxt;
      vcc_r       <= vcc_nxt;
      vpp_r       <= vpp_nxt;
      hv_r        <= hv_nxt;
      match_r     <= match_nxt;
      pass_r      <= pass_nxt;
      fail_r      <= fail_nxt;
      done_r      <= done_nxt;
      fail_addr_r <= fail_addr_nxt;
      mfr_r       <= mfr_nxt;
      dev_r       <= dev_nxt;
    end
  end

  assign busy                = (state_r != ST_IDLE);
  assign done                = done_r;
  assign pass                = pass_r;
  assign fail                = fail_r;
  assign fail_addr           = fail_addr_r;
  assign mfr_code            = mfr_r;
  assign dev_code            = dev_r;
  assign src_addr            = addr_r;
  assign mem_addr            = addr_r;
  assign ce_n                = ce_n_r;
  assign oe_n                = oe_n_r;
  assign data_out_lines_out  = dout_r;
  assign data_out_lines_oe_n = doe_n_r;
  assign vcc_prog_en         = vcc_r;
  assign vpp_prog_en         = vpp_r;
  assign id_voltage_line_en  = hv_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [TMR_W-1:0] pw_cnt_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_cnt_r <= '0;
    end else if (!ce_n_r && !doe_n_r) begin
      pw_cnt_r <= pw_cnt_r + 14'h0001;
    end else begin
      pw_cnt_r <= '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pulse_begins;
    !ce_n_r && !doe_n_r && vpp_r ##1 !ce_n_r;
  endsequence

  sequence s_verify_read;
    !ce_n_r && oe_n_r ##1 !ce_n_r;
  endsequence

  chk_pulse_start: assert property (
    state_r == ST_PSET && tmr_if.done |=> s_pulse_begins)
    else $error("program pulse did not start after data setup");

  chk_pulse_width: assert property (
    $rose(ce_n_r) && !doe_n_r |-> pw_cnt_r == PULSE_CHK)
    else $error("program pulse width wrong");

  chk_start_addr: assert property (
    $rose(vcc_r) |-> addr_r == FIRST_ADDR && phase_r == PH_FIRST)
    else $error("programming did not start at first address");

  chk_supply_up: assert property (
    !ce_n_r && !doe_n_r |-> vcc_r && vpp_r)
    else $error("pulse without programming supplies");

  chk_no_verify: assert property (
    phase_r == PH_FIRST |-> oe_n_r)
    else $error("read during first pass");

  chk_retry_cap: assert property (
    state_r == ST_PULSE && phase_r == PH_VERIFY |-> try_cnt < MAX_TRIES)
    else $error("more than ten retry pulses");

  chk_fail_stop: assert property (
    state_r == ST_FLOAT && tmr_if.done && phase_r == PH_VERIFY
    && !match_r && try_lim |=> fail_r && state_r == ST_VPPDN)
    else $error("failed byte did not stop the run");

  chk_advance: assert property (
    state_r == ST_FLOAT && tmr_if.done && phase_r == PH_VERIFY
    && match_r && !last |=> addr_r == $past(addr_r) + 15'h0001
    ##1 s_verify_read)
    else $error("verified byte did not advance");

  chk_read_level: assert property (
    phase_r == PH_FINAL |-> !vpp_r && !vcc_r)
    else $error("final read not at read supply level");

  chk_final_fail: assert property (
    state_r == ST_FLOAT && tmr_if.done && phase_r == PH_FINAL
    && !match_r |=> fail_r ##1 done_r)
    else $error("read-back mismatch not reported");

  chk_id_voltage: assert property (
    phase_r == PH_ID && !oe_n_r |-> id_voltage_line_en)
    else $error("id read without elevated voltage");

  chk_read_pins: assert property (
    !oe_n_r |-> !ce_n_r && doe_n_r)
    else $error("read with chip select high or bus driven");

endmodule // otpp_prog_ctrl

// >>> common/otpp_pkg.sv
package otpp_pkg;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int              ADDR_W    = 15;
  localparam int              DATA_W    = 8;
  localparam int              TMR_W     = 14;
  localparam logic [14:0]     FIRST_ADDR = 15'h0000;
  localparam logic [14:0]     LAST_ADDR = 15'h7fff;
  localparam logic [3:0]      MAX_TRIES = 4'ha;

  // ****************************************
  // Timing, in printed units, then cycles
  // ****************************************
  localparam int CLK_MHZ       = 100;
  localparam int PULSE_US      = 100;
  localparam int PW_MIN_US     = 95;
  localparam int PW_MAX_US     = 105;
  localparam int SETUP_US      = 2;
  localparam int DATA_VALID_NS = 150;
  localparam int FLOAT_NS      = 130;
  localparam int PULSE_CYC     = PULSE_US * CLK_MHZ;
  localparam int PW_MIN_CYC    = PW_MIN_US * CLK_MHZ;
  localparam int PW_MAX_CYC    = PW_MAX_US * CLK_MHZ;
  localparam int SETUP_CYC     = SETUP_US * CLK_MHZ;
  localparam int DV_CYC        = (DATA_VALID_NS * CLK_MHZ + 999) / 1000;
  localparam int FLOAT_CYC     = (FLOAT_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Sequencer states and phases
  // ****************************************
  typedef enum logic [11:0] {
    ST_IDLE  = 12'h001,
    ST_VCCUP = 12'h002,
    ST_VPPUP = 12'h004,
    ST_PSET  = 12'h008,
    ST_PULSE = 12'h010,
    ST_PHOLD = 12'h020,
    ST_RSET  = 12'h040,
    ST_ROE   = 12'h080,
    ST_FLOAT = 12'h100,
    ST_VPPDN = 12'h200,
    ST_VCCDN = 12'h400,
    ST_DONE  = 12'h800
  } otpp_state_t;

  typedef enum logic [3:0] {
    PH_FIRST  = 4'h1,
    PH_VERIFY = 4'h2,
    PH_FINAL  = 4'h4,
    PH_ID     = 4'h8
  } otpp_phase_t;

endpackage

// >>> common/otpp_tmr_if.sv
interface otpp_tmr_if;
  logic        load;
  logic [13:0] count;
  logic        done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// >>> design/otpp_delay.sv
module otpp_delay (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Delay request
  otpp_tmr_if.tmr   tmr
);
  import otpp_pkg::*;

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;

  // Done marks the last cycle of a loaded count, so a state lasts exactly N.
  always_comb begin
    cnt_nxt = cnt_r;
    if (tmr.load) begin
      cnt_nxt = tmr.count;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 14'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tmr.done = (cnt_r == 14'h0001);

endmodule // otpp_delay

// >>> design/otpp_retry.sv
module otpp_retry (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       clr,
  input  wire logic       inc,
  // Status
  output logic [3:0]      count,
  output logic            limit
);
  import otpp_pkg::*;

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = 4'h0;
    end else if (inc && cnt_r != MAX_TRIES) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
  assign limit = (cnt_r == MAX_TRIES);

endmodule // otpp_retry

// >>> dv/otpp_dev_model.sv
module otpp_dev_model #(
  // Arbitrary identity values, chosen only to tell the two codes apart.
  parameter logic [7:0] MFR_ID = 8'h5a,
  parameter logic [7:0] DEV_ID = 8'h3c
) (
  // Clock used to time pulses, count reads and flip the released lines
  input  wire logic        ref_clk,
  // Device pins
  input  wire logic [14:0] mem_addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  host_data,
  input  wire logic        host_oe_n,
  input  wire logic        vcc_prog_en,
  input  wire logic        vpp_prog_en,
  input  wire logic        id_voltage_line_en,
  // Resolved data lines and observation counters
  output logic [7:0]       bus,
  output int               pw_last,
  output int               n_pulse,
  output int               n_read
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Storage and read path
  // ****************************************
  logic [7:0]  mem [0:32767];
  logic [7:0]  rd_val;
  logic [7:0]  last_q;
  logic [7:0]  lat_d;
  logic [14:0] lat_a;
  logic        saw_oe;
  logic        oe_q;
  int          cnt;

  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
    last_q = 8'h00;
    pw_last = 0;
    n_pulse = 0;
    n_read = 0;
    cnt = 0;
    saw_oe = 1'b0;
    oe_q = 1'b1;
  end

  always_comb begin
    if (id_voltage_line_en) rd_val = mem_addr[0] ? DEV_ID : MFR_ID;
    else rd_val = mem[mem_addr];
  end

  // Released lines have no pull, so they show a value that flips each cycle.
  always_comb begin
    if (!host_oe_n) bus = host_data;
    else if (!ce_n && !oe_n) bus = rd_val;
    else bus = ~last_q;
  end

  // ****************************************
  // Pulse timing and programming
  // ****************************************
  always @(posedge ref_clk) begin
    last_q <= bus;
    oe_q <= oe_n;
    if (oe_q && !oe_n) n_read <= n_read + 1;
    if (!ce_n) begin
      cnt <= cnt + 1;
      lat_a <= mem_addr;
      lat_d <= host_data;
      if (!oe_n) saw_oe <= 1'b1;
    end else begin
      // Only a chip-select pulse with program supply and no read burns bits.
      if (cnt != 0 && !saw_oe && vcc_prog_en && vpp_prog_en
          && !host_oe_n) begin
        mem[lat_a] <= mem[lat_a] & lat_d;
        pw_last <= cnt;
        n_pulse <= n_pulse + 1;
      end
      cnt <= 0;
      saw_oe <= 1'b0;
    end
  end

endmodule // otpp_dev_model

// >>> dv/otpp_prog_ctrl_tb_top.sv
module otpp_prog_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import otpp_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  localparam int P   = 20;
  localparam int TMO = 30000;
  // A short image lets the verify and read-back passes run in a few
  // thousand cycles.
  localparam logic [ADDR_W-1:0] L = 15'h0003;

  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              prog_start = 1'b0;
  logic              id_start = 1'b0;
  logic              busy, done, pass, fail;
  logic [ADDR_W-1:0] fail_addr, src_addr, mem_addr;
  logic [DATA_W-1:0] mfr_code, dev_code, src_data, bus, dout;
  logic              ce_n, oe_n, dout_oe_n;
  logic              vcc_prog_en, vpp_prog_en, id_voltage_line_en;
  logic [DATA_W-1:0] img_flip = 8'h00;
  int                err_count = 0;
  int                n_compared = 0;
  int                cyc = 0;

  function automatic logic [DATA_W-1:0] src_byte(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction

  assign src_data = src_byte(src_addr) ^ img_flip;

  otpp_prog_ctrl #(.PULSE_CYC(P), .LAST_A(L)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .prog_start(prog_start), .id_start(id_start),
    .busy(busy), .done(done), .pass(pass), .fail(fail),
    .fail_addr(fail_addr), .mfr_code(mfr_code), .dev_code(dev_code),
    .src_addr(src_addr), .src_data(src_data),
    .mem_addr(mem_addr), .ce_n(ce_n), .oe_n(oe_n),
    .data_out_lines_in(bus), .data_out_lines_out(dout),
    .data_out_lines_oe_n(dout_oe_n),
    .vcc_prog_en(vcc_prog_en), .vpp_prog_en(vpp_prog_en),
    .id_voltage_line_en(id_voltage_line_en)
  );

  otpp_dev_model u_dev (
    .ref_clk(ref_clk), .mem_addr(mem_addr), .ce_n(ce_n), .oe_n(oe_n),
    .host_data(dout), .host_oe_n(dout_oe_n),
    .vcc_prog_en(vcc_prog_en), .vpp_prog_en(vpp_prog_en),
    .id_voltage_line_en(id_voltage_line_en),
    .bus(bus), .pw_last(), .n_pulse(), .n_read()
  );

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A hang in any wait loop ends here as a mismatch.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == TMO) begin
      err_count++;
      end_of_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_vals;
    rst_n = 1'b0;
    repeat (3) step;
    chk({busy, done, pass, fail}, 4'h0);
    chk({ce_n, oe_n, dout_oe_n}, 3'h7);
    chk({vcc_prog_en, vpp_prog_en, id_voltage_line_en}, 3'h0);
    chk(mem_addr, 15'h0000);
    chk({fail_addr, src_addr}, 30'h00000000);
    chk({mfr_code, dev_code}, 16'h0000);
    rst_n = 1'b1;
  endtask

  task automatic t_id_run;
    int n0;
    n0 = u_dev.n_read;
    id_start = 1'b1;
    step;
    id_start = 1'b0;
    chk(busy, 1'b1);
    chk(id_voltage_line_en, 1'b1);
    chk(vpp_prog_en, 1'b0);
    while (done !== 1'b1) step;
    chk(mfr_code, u_dev.MFR_ID);
    chk(dev_code, u_dev.DEV_ID);
    chk(u_dev.n_read - n0, 2);
    chk({pass, fail}, 2'h0);
    step;
    chk(busy, 1'b0);
  endtask

  task automatic t_prog_head;
    int n, p0, r0;
    p0 = u_dev.n_pulse;
    r0 = u_dev.n_read;
    prog_start = 1'b1;
    step;
    prog_start = 1'b0;
    id_start = 1'b1;
    step;
    id_start = 1'b0;
    while (vcc_prog_en !== 1'b1) step;
    chk(vpp_prog_en, 1'b0);
    // One edge has already passed since the main supply rose.
    n = 1;
    while (vpp_prog_en !== 1'b1) begin
      step;
      n++;
    end
    chk(n, SETUP_CYC);
    for (int k = 0; k < 3; k++) begin
      while (ce_n !== 1'b0) step;
      chk(mem_addr, k);
      chk({dout_oe_n, vcc_prog_en, vpp_prog_en}, 3'h3);
      chk(dout, src_byte(k));
      while (ce_n !== 1'b1) step;
      step;
      chk(u_dev.pw_last, P);
      chk(u_dev.mem[k], src_byte(k));
      chk(u_dev.n_pulse - p0, k + 1);
    end
    chk(u_dev.n_read - r0, 0);
    chk({busy, id_voltage_line_en}, 2'h2);
  endtask

  task automatic t_prog_full;
    int p0, r0;
    p0 = u_dev.n_pulse;
    r0 = u_dev.n_read;
    prog_start = 1'b1;
    step;
    prog_start = 1'b0;
    while (done !== 1'b1) step;
    chk({pass, fail}, 2'h2);
    chk(u_dev.n_pulse - p0, L + 1);
    chk(u_dev.n_read - r0, 2 * (L + 1));
    chk(u_dev.mem[L], src_byte(L));
    chk({vcc_prog_en, vpp_prog_en}, 2'h0);
  endtask

  // This image asks for bits at the first address that are already burnt
  // away, so that byte can never verify and the retries must run out.
  task automatic t_prog_fail;
    int p0, r0;
    img_flip = 8'h5a;
    p0 = u_dev.n_pulse;
    r0 = u_dev.n_read;
    prog_start = 1'b1;
    step;
    prog_start = 1'b0;
    while (done !== 1'b1) step;
    chk({pass, fail}, 2'h1);
    chk(fail_addr, FIRST_ADDR);
    chk(u_dev.n_pulse - p0, L + 1 + MAX_TRIES);
    chk(u_dev.n_read - r0, MAX_TRIES + 1);
    chk({vcc_prog_en, vpp_prog_en}, 2'h0);
    img_flip = 8'h00;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    t_reset_vals();
    t_id_run();
    t_prog_head();
    // A reset in mid-pass must abort the run cleanly.
    t_reset_vals();
    t_id_run();
    t_prog_full();
    t_prog_fail();
    end_of_test();
  end

endmodule // otpp_prog_ctrl_tb_top
